// [rtl/sfr_defines.svh]
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
// ****************************************
// register byte offsets
// ****************************************
`define SFR_A_CTRL 8'h00
`define SFR_A_STAT 8'h04
`define SFR_A_NVCR 8'h08
`define SFR_A_VCFG 8'h0c
`define SFR_A_INFO 8'h10
// control fields
`define SFR_C_PRLO 0
`define SFR_C_PRHI 1
`define SFR_C_A4 2
`define SFR_C_DTR 3
`define SFR_C_PERR 4
// status and flag bits
`define SFR_S_WIP 0
`define SFR_S_WEL 1
`define SFR_S_SRWD 7
`define SFR_F_RDY 7
`define SFR_F_PROT 1
// reset values and reserved masks
`define SFR_SR_RST 8'h00
`define SFR_NVCR_RST 16'hffff
`define SFR_NVCR_RSV 16'h0010
`define SFR_VCR_RST 8'hfb
`define SFR_VCR_RSV 8'h04
`define SFR_EVCR_RST 8'hdf
`define SFR_EVCR_RSV 8'h10
`define SFR_EAR_RST 8'h00
`define SFR_EAR_RSV 8'hfe
// ****************************************
// timing
// ****************************************
`define SFR_CLK_MHZ 40
`define SFR_TW_US 1000
`define SFR_TNV_US 2000
`define SFR_TW_CYC (`SFR_TW_US * `SFR_CLK_MHZ)
`define SFR_TNV_CYC (`SFR_TNV_US * `SFR_CLK_MHZ)
`endif

// [rtl/sfr_pkg.sv]
// ****************************************
// shared types
// ****************************************
package sfr_pkg;
  typedef enum logic [1:0] {
    PR_EXT = 2'h0, PR_DUAL = 2'h1, PR_QUAD = 2'h2
  } sfr_proto_e;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_CMD = 5'h02, ST_WIN = 5'h04,
    ST_OUT = 5'h08, ST_SKIP = 5'h10
  } sfr_state_e;
endpackage : sfr_pkg

// [rtl/sfr_lnk_if.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// synchronised link view
// ****************************************
interface sfr_lnk_if;
  logic cs_n, csf, csr, rise, fall, wp_n;
  logic [3:0] dq;
  modport src(output cs_n, csf, csr, rise, fall, wp_n, dq);
  modport dst(input cs_n, csf, csr, rise, fall, wp_n, dq);
endinterface : sfr_lnk_if
`default_nettype wire

// [rtl/sfr_front.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// pin synchroniser and edge finder
// ****************************************
module sfr_front (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic wp_n_i,
  input wire logic [3:0] dq_i,
  sfr_lnk_if.src lk
);
  logic [6:0] s1_r, s2_r;
  logic [1:0] p_r;
  // two flops, then previous value of clock and select
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= 7'h41;
      s2_r <= 7'h41;
      p_r <= 2'h1;
    end else begin
      s1_r <= {wp_n_i, dq_i, sck_i, cs_n_i};
      s2_r <= s1_r;
      p_r <= s2_r[1:0];
    end
  end
  assign lk.cs_n = s2_r[0];
  assign lk.rise = s2_r[1] & ~p_r[1] & ~s2_r[0];
  assign lk.fall = ~s2_r[1] & p_r[1] & ~s2_r[0];
  assign lk.csf = ~s2_r[0] & p_r[0];
  assign lk.csr = s2_r[0] & ~p_r[0];
  assign lk.dq = s2_r[5:2];
  assign lk.wp_n = s2_r[6];
endmodule : sfr_front
`default_nettype wire

// [rtl/sfr_timer.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// self-timed operation counter
// ****************************************
module sfr_timer #(parameter int W = 32) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [W-1:0] load_i,
  output logic busy_o,
  output logic done_o
);
  logic [W-1:0] cnt_r;
  if (W < 2) begin : g_chk
    $error("sfr_timer: W too small");
  end
  // count down to zero, pulse on the last cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r <= '0;
    end else if (start_i) begin
      cnt_r <= load_i;
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - 1'b1;
    end
  end
  assign busy_o = (cnt_r != '0);
  assign done_o = (cnt_r == {{(W-1){1'b0}}, 1'b1}) & ~start_i;
endmodule : sfr_timer
`default_nettype wire

// [rtl/sfr_unit.sv]
// The address map and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.svh"
module sfr_unit import sfr_pkg::*; #(
  parameter int TW_CYC = `SFR_TW_CYC,
  parameter int TNV_CYC = `SFR_TNV_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cs_n_i,
  input wire logic sck_i,
  input wire logic wp_n_i,
  input wire logic [3:0] dq_i,
  output logic [3:0] dq_o,
  output logic [3:0] dq_oe_o
);
  if (TW_CYC < 1 || TNV_CYC < 1) begin : g_chk
    $error("sfr_unit: write times must be at least one cycle");
  end
  sfr_lnk_if lk ();
  sfr_state_e st_r;
  sfr_proto_e pr;
  logic [7:0] ctrl_r, sr_r, vcr_r, evcr_r, ear_r, sh_r, cmd_r, op_r;
  logic [7:0] nsh, srv, fsr;
  logic [15:0] nvcr_r, wbuf_r;
  logic [15:0] info_r;
  logic [2:0] bi_r, ob_r;
  logic [3:0] ln, bsum, osum;
  logic [1:0] nb_r, need, nbo_r;
  logic wel_r, perr_r, busy, done, start, ok, wr_go, ack_r;
  logic [31:0] rd_nxt, tload;

  // ****************************************
  // front end and timer
  // ****************************************
  sfr_front u_front (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(cs_n_i), .sck_i(sck_i),
    .wp_n_i(wp_n_i), .dq_i(dq_i), .lk(lk)
  );
  sfr_timer #(.W(32)) u_tmr (
    .clk_i(clk_i), .rst_i(rst_i), .start_i(start), .load_i(tload),
    .busy_o(busy), .done_o(done)
  );

  // ****************************************
  // helpers
  // ****************************************
  // address phase cycles per command, protocol and address mode
  function automatic logic [5:0] acyc(input logic [7:0] c,
      input sfr_proto_e p, input logic a4);
    logic [5:0] t;
    logic [5:0] r;
    t = a4 ? 6'd32 : 6'd24;
    r = 6'd0;
    case (c)
      8'h0d, 8'h0e: begin
        if (p == PR_EXT) r = 6'd7 + (t >> 1);
        else if (p == PR_DUAL) r = 6'd3 + (t >> 2);
        else r = 6'd1 + (t >> 3);
      end
      8'h3d: begin
        if (p == PR_EXT) r = 6'd7 + (t >> 1);
        else if (p == PR_DUAL) r = 6'd3 + (t >> 2);
      end
      8'h6d: begin
        if (p == PR_EXT) r = 6'd7 + (t >> 1);
        else if (p == PR_QUAD) r = 6'd1 + (t >> 3);
      end
      8'hbd: begin
        if (p == PR_EXT) r = 6'd7 + (t >> 2);
        else if (p == PR_DUAL) r = 6'd3 + (t >> 3);
      end
      8'hed: begin
        if (p == PR_EXT) r = 6'd7 + (t >> 3);
        else if (p == PR_QUAD) r = 6'd1 + (t >> 3);
      end
      8'he7: begin
        if (p == PR_EXT) r = 6'd7 + (t >> 2);
        else if (p == PR_QUAD) r = 6'd1 + (t >> 2);
      end
      default: r = 6'd0;
    endcase
    return r;
  endfunction : acyc

  // byte presented by a register read
  function automatic logic [7:0] rbyte(input logic [7:0] c,
      input logic [1:0] i, input logic [7:0] s, input logic [7:0] f,
      input logic [15:0] nv, input logic [7:0] v, input logic [7:0] e,
      input logic [7:0] x);
    logic [7:0] r;
    r = 8'h00;
    case (c)
      8'h05: r = s;
      8'h70: r = f;
      8'hb5: begin
        if (i == 2'd0) r = nv[7:0];
        else if (i == 2'd1) r = nv[15:8];
      end
      8'h85: r = v;
      8'h65: r = e;
      8'hc8: r = x;
      default: r = 8'h00;
    endcase
    return r;
  endfunction : rbyte

  assign pr = sfr_proto_e'(ctrl_r[`SFR_C_PRHI:`SFR_C_PRLO]);
  // lanes per edge
  always_comb begin
    case (pr)
      PR_DUAL: ln = 4'd2;
      PR_QUAD: ln = 4'd4;
      default: ln = 4'd1;
    endcase
  end
  // shift in from lane zero upward
  always_comb begin
    case (pr)
      PR_DUAL: nsh = {sh_r[5:0], lk.dq[1:0]};
      PR_QUAD: nsh = {sh_r[3:0], lk.dq[3:0]};
      default: nsh = {sh_r[6:0], lk.dq[0]};
    endcase
  end
  assign bsum = {1'b0, bi_r} + ln;
  assign osum = {1'b0, ob_r} + ln;
  assign srv = {sr_r[7:2], wel_r, busy};
  always_comb begin
    fsr = 8'h00;
    fsr[`SFR_F_RDY] = ~busy;
    fsr[`SFR_F_PROT] = perr_r;
  end
  // data bytes a command needs before select may rise
  always_comb begin
    case (cmd_r)
      8'hb1: need = 2'd2;
      8'h01, 8'h81, 8'h61, 8'hc5: need = 2'd1;
      default: need = 2'd0;
    endcase
  end
  // select rose on a whole byte boundary
  assign ok = lk.csr && bi_r == 3'd0 && nb_r == need &&
    (st_r == ST_WIN || st_r == ST_SKIP);
  assign wr_go = ok && wel_r && !busy;
  assign start = wr_go && (cmd_r == 8'h01 || cmd_r == 8'hb1);
  assign tload = (cmd_r == 8'hb1) ? TNV_CYC : TW_CYC;

  // ****************************************
  // link state machine
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || lk.cs_n) begin
      st_r <= ST_IDLE;
      bi_r <= 3'd0;
      nb_r <= 2'd0;
    end else if (lk.csf) begin
      st_r <= ST_CMD;
    end else if (lk.rise) begin
      bi_r <= bsum[2:0];
      if (st_r != ST_CMD && bsum[3] && nb_r != 2'd3) begin
        nb_r <= nb_r + 2'd1;
      end
      if (st_r == ST_CMD && bsum[3]) begin
        case (nsh)
          8'h05, 8'h70, 8'hb5, 8'h85, 8'h65, 8'hc8: st_r <= ST_OUT;
          8'h01, 8'hb1, 8'h81, 8'h61, 8'hc5: st_r <= ST_WIN;
          default: st_r <= ST_SKIP;
        endcase
      end
    end
  end
  // shift register, command and written data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sh_r <= 8'h00;
      cmd_r <= 8'h00;
      wbuf_r <= 16'h0000;
      info_r <= '0;
    end else if (lk.rise && !lk.cs_n) begin
      sh_r <= nsh;
      if (st_r == ST_CMD && bsum[3]) begin
        cmd_r <= nsh;
        info_r <= {(nsh == 8'he7) && (pr == PR_DUAL || ctrl_r[`SFR_C_DTR]),
          ctrl_r[`SFR_C_DTR] || nsh inside {8'h0d, 8'h0e, 8'h3d, 8'h6d,
          8'hbd, 8'hed}, acyc(nsh, pr, ctrl_r[`SFR_C_A4]), nsh};
      end
      if (st_r == ST_WIN && bsum[3]) begin
        wbuf_r <= {nsh, wbuf_r[15:8]};
      end
    end
  end

  // ****************************************
  // read output
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i || lk.cs_n) begin
      op_r <= 8'h00;
      ob_r <= 3'd0;
      nbo_r <= 2'd0;
      dq_o <= 4'h0;
      dq_oe_o <= 4'h0;
    end else if (lk.rise && st_r == ST_CMD && bsum[3]) begin
      op_r <= rbyte(nsh, 2'd0, srv, fsr, nvcr_r | `SFR_NVCR_RSV, vcr_r,
        evcr_r, ear_r);
      nbo_r <= 2'd1;
    end else if (lk.fall && st_r == ST_OUT) begin
      case (pr)
        PR_DUAL: begin
          dq_o <= {2'b00, op_r[7:6]};
          dq_oe_o <= 4'h3;
        end
        PR_QUAD: begin
          dq_o <= op_r[7:4];
          dq_oe_o <= 4'hf;
        end
        default: begin
          dq_o <= {2'b00, op_r[7], 1'b0};
          dq_oe_o <= 4'h2;
        end
      endcase
      ob_r <= osum[2:0];
      if (osum[3]) begin
        op_r <= rbyte(cmd_r, nbo_r, srv, fsr, nvcr_r | `SFR_NVCR_RSV,
          vcr_r, evcr_r, ear_r);
        if (nbo_r != 2'd3) nbo_r <= nbo_r + 2'd1;
      end else begin
        op_r <= op_r << ln;
      end
    end
  end

  // ****************************************
  // command execution
  // ****************************************
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wel_r <= 1'b0;
      perr_r <= 1'b0;
    end else begin
      if (done) wel_r <= 1'b0;
      if (ok && !busy && cmd_r == 8'h06) wel_r <= 1'b1;
      if (ok && !busy && cmd_r == 8'h04 && !perr_r) wel_r <= 1'b0;
      if (ok && cmd_r == 8'h50) begin
        wel_r <= 1'b0;
        perr_r <= 1'b0;
      end
      if (ack_r && wb_we_i && wb_adr_i == `SFR_A_CTRL && wb_sel_i[0] &&
          wb_dat_i[`SFR_C_PERR]) begin
        perr_r <= 1'b1;
      end
    end
  end
  // configuration and status storage
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sr_r <= `SFR_SR_RST;
      nvcr_r <= `SFR_NVCR_RST;
      vcr_r <= `SFR_VCR_RST;
      evcr_r <= `SFR_EVCR_RST;
      ear_r <= `SFR_EAR_RST;
    end else if (wr_go) begin
      case (cmd_r)
        8'h01: begin
          if (!(sr_r[`SFR_S_SRWD] && !lk.wp_n)) begin
            sr_r <= {wbuf_r[15:10], sr_r[1:0]};
          end
        end
        8'hb1: nvcr_r <= wbuf_r;
        8'h81: vcr_r <= (wbuf_r[15:8] & ~`SFR_VCR_RSV) |
          (vcr_r & `SFR_VCR_RSV);
        8'h61: evcr_r <= (wbuf_r[15:8] & ~`SFR_EVCR_RSV) |
          (evcr_r & `SFR_EVCR_RSV);
        8'hc5: ear_r <= (wbuf_r[15:8] & ~`SFR_EAR_RSV) |
          (ear_r & `SFR_EAR_RSV);
        default: sr_r <= sr_r;
      endcase
    end
  end

  // ****************************************
  // wishbone slave
  // ****************************************
  always_comb begin
    rd_nxt = 32'h0000_0000;
    if (wb_adr_i == `SFR_A_CTRL) rd_nxt = {24'h0, ctrl_r};
    else if (wb_adr_i == `SFR_A_STAT) rd_nxt = {16'h0, fsr, srv};
    else if (wb_adr_i == `SFR_A_NVCR) rd_nxt = {16'h0, nvcr_r};
    else if (wb_adr_i == `SFR_A_VCFG) rd_nxt = {8'h0, ear_r, evcr_r, vcr_r};
    else if (wb_adr_i == `SFR_A_INFO) rd_nxt = {16'h0, info_r};
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      ctrl_r <= 8'h00;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r && !wb_ack_o;
      wb_ack_o <= wb_cyc_i && wb_stb_i && !ack_r && !wb_ack_o;
      wb_dat_o <= rd_nxt;
      if (ack_r && wb_cyc_i && wb_stb_i && wb_we_i &&
          wb_adr_i == `SFR_A_CTRL && wb_sel_i[0]) begin
        ctrl_r <= {4'h0, wb_dat_i[3:0]};
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  a_wren_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    ok && !busy && cmd_r == 8'h06 |=> wel_r)
    else $error("write enable did not set latch");
  a_wren_extra: assert property (@(posedge clk_i) disable iff (rst_i)
    lk.csr && cmd_r == 8'h06 && st_r == ST_SKIP && bi_r != 3'd0 && !wel_r
    |=> !wel_r)
    else $error("misaligned write enable set latch");
  a_wrdi_perr: assert property (@(posedge clk_i) disable iff (rst_i)
    ok && cmd_r == 8'h04 && perr_r && wel_r |=> wel_r)
    else $error("write disable cleared latch under error");
  a_wr_misalign: assert property (@(posedge clk_i) disable iff (rst_i)
    lk.csr && st_r == ST_WIN && bi_r != 3'd0 |=> $stable(sr_r) && !busy
    || $past(busy))
    else $error("misaligned write executed");
  a_sr_low_kept: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 sr_r[1:0] == $past(sr_r[1:0]))
    else $error("status low bits changed");
  a_wr_busy: assert property (@(posedge clk_i) disable iff (rst_i)
    start |=> busy [*8])
    else $error("write not held busy");
  a_done_clr: assert property (@(posedge clk_i) disable iff (rst_i)
    done |=> !wel_r && !busy)
    else $error("completion left latch or busy");
  a_nowel_nowr: assert property (@(posedge clk_i) disable iff (rst_i)
    ok && !wel_r |=> $stable(vcr_r) && $stable(nvcr_r))
    else $error("write took effect without latch");
  a_vcr_rsv: assert property (@(posedge clk_i) disable iff (rst_i)
    ##1 (vcr_r & `SFR_VCR_RSV) == ($past(vcr_r) & `SFR_VCR_RSV))
    else $error("reserved volatile bit changed");
  a_ext_lane: assert property (@(posedge clk_i) disable iff (rst_i)
    pr == PR_EXT && dq_oe_o != 4'h0 |-> dq_oe_o == 4'h2)
    else $error("extended read on wrong lane");
  c_wren: cover property (@(posedge clk_i) ok && cmd_r == 8'h06);
  c_wrsr: cover property (@(posedge clk_i) start && cmd_r == 8'h01);
  c_rdsr: cover property (@(posedge clk_i) lk.fall && st_r == ST_OUT);
endmodule : sfr_unit
`default_nettype wire

// [tb/sfr_host.sv]
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// host link controller model
// ****************************************
module sfr_host (
  output logic cs_n_o,
  output logic sck_o,
  output logic [3:0] dq_o,
  input wire logic [3:0] dq_i
);
  logic [7:0] rx_q[$];
  logic [3:0] smp;
  // idle: deselected, clock parked low
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    dq_o = 4'h0;
  end
  // one clock pulse, lanes sampled just before the fall
  task automatic clk1();
    #100 sck_o = 1'b1;
    #90 smp = dq_i;
    #10 sck_o = 1'b0;
  endtask : clk1
  // one frame: bytes out, stray bits, then bytes in
  task automatic frame(input int lanes, input logic [7:0] tx[$],
      input int xbits, input int nin);
    logic [7:0] b;
    logic [3:0] m;
    m = 4'((5'h1 << lanes) - 5'h1);
    rx_q.delete();
    #155 cs_n_o = 1'b0; // pin edges stay off the bench clock edges
    foreach (tx[i]) begin
      b = tx[i];
      repeat (8 / lanes) begin
        dq_o = 4'(b >> (8 - lanes)) & m;
        b = b << lanes;
        clk1();
      end
    end
    repeat (xbits) begin
      dq_o = 4'($urandom) & m;
      clk1();
    end
    repeat (nin) begin
      b = 8'h00;
      repeat (8 / lanes) begin
        dq_o = ~dq_o; // released lanes never hold a value
        clk1();
        b = (b << lanes) | ((lanes == 1) ? {7'h0, smp[1]} : {4'h0, smp & m});
      end
      rx_q.push_back(b);
    end
    #150 cs_n_o = 1'b1;
    dq_o = ~dq_o;
    #145;
  endtask : frame
endmodule : sfr_host
`default_nettype wire

// [tb/sfr_unit_tb.sv]
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defines.svh"
// ****************************************
// register command unit bench
// ****************************************
module sfr_unit_tb;
  logic clk_i, rst_i, cyc, stb, we, wp_n, ack, cs_n, sck;
  logic [7:0] adr, v, e;
  logic [15:0] nv;
  logic [3:0] dq_o, oe, h_dq, lane;
  logic [31:0] dat, dat_o, rd;
  logic [7:0] tx[$];
  logic [7:0] cur[3];
  int fails, checks_done, lanes, ex;
  logic [7:0] cmds[7] = '{8'h0d, 8'h0e, 8'h3d, 8'h6d, 8'hbd, 8'hed, 8'he7};
  logic [7:0] rsv[3] = '{8'h04, 8'h10, 8'hfe};
  logic [7:0] wcmd[3] = '{8'h81, 8'h61, 8'hc5};
  logic [7:0] rcmd[3] = '{8'h85, 8'h65, 8'hc8};
  // wire level from both drivers
  assign lane = (oe & dq_o) | (~oe & h_dq);
  sfr_unit #(.TW_CYC(400), .TNV_CYC(600)) sfr_unit_i (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .cs_n_i(cs_n), .sck_i(sck), .wp_n_i(wp_n),
    .dq_i(lane), .dq_o(dq_o), .dq_oe_o(oe));
  sfr_host sfr_host_i (.cs_n_o(cs_n), .sck_o(sck), .dq_o(h_dq),
    .dq_i(lane));
  // address phase length per command and protocol, -1 if unsupported
  function automatic int exp_cyc(logic [7:0] c, int p, int t1);
    int d;
    d = (c == 8'hbd || c == 8'he7) ? 4 : (c == 8'hed) ? 8 : 2;
    if (p == 0) return 7 + t1 / d;
    if (c == 8'he7) return (p == 2) ? 1 + t1 / 4 : -1;
    if (p == 1 && c inside {8'h0d, 8'h0e, 8'h3d}) return 3 + t1 / 4;
    if (p == 1 && c == 8'hbd) return 3 + t1 / 8;
    if (p == 2 && c inside {8'h0d, 8'h0e, 8'h6d, 8'hed}) return 1 + t1 / 8;
    return -1;
  endfunction : exp_cyc
  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // classic single wishbone cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do @(posedge clk_i); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic go(input int x, input int nin);
    sfr_host_i.frame(lanes, tx, x, nin);
  endtask : go
  task automatic spi1(input logic [7:0] c);
    tx = {c};
    go(0, 0);
  endtask : spi1
  task automatic setp(input int p, input logic a4);
    wb(1'b1, `SFR_A_CTRL, {29'h0, a4, 2'(p)});
    lanes = (p == 0) ? 1 : (p == 1) ? 2 : 4;
  endtask : setp
  task automatic waitidle();
    do wb(1'b0, `SFR_A_STAT, 0); while (rd[0] !== 1'b0);
  endtask : waitidle
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  // clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    fails++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    rst_i = 1'b1;
    {cyc, stb, we, adr, dat} = '0;
    wp_n = 1'b1;
    fails = 0;
    checks_done = 0;
    lanes = 1;
    void'($urandom(40742));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, `SFR_A_STAT, 0);
    chk("stat", 32'h8000, rd);
    wb(1'b0, `SFR_A_VCFG, 0);
    chk("vcfg", 32'hdffb, rd);
    wb(1'b1, 8'h14, 32'hffffffff);
    wb(1'b0, 8'h14, 0);
    chk("unmapped", 0, rd);
    $display("reset test done");
    for (int p = 0; p < 3; p++) begin
      setp(p, 1'b0);
      spi1(8'h06);
      tx = {8'h05};
      go(0, 2);
      chk("sr first", 32'h02, sfr_host_i.rx_q[0]);
      chk("sr again", 32'h02, sfr_host_i.rx_q[1]);
      spi1(8'h04);
      tx = {8'h70};
      go(0, 1);
      chk("flag", 32'h80, sfr_host_i.rx_q[0]);
      wb(1'b0, `SFR_A_STAT, 0);
      chk("latch off", 32'h8000, rd);
    end
    setp(0, 1'b0);
    tx = {8'h06};
    go(1 + $urandom % 7, 0);
    wb(1'b0, `SFR_A_STAT, 0);
    chk("cut enable", 32'h8000, rd);
    spi1(8'h06);
    wb(1'b1, `SFR_A_CTRL, 32'h10);
    spi1(8'h04);
    wb(1'b0, `SFR_A_STAT, 0);
    chk("prot kept", 32'h8202, rd);
    spi1(8'h50);
    wb(1'b0, `SFR_A_STAT, 0);
    chk("prot clr", 32'h8000, rd);
    $display("latch test done");
    tx = {8'h81, 8'($urandom)};
    go(0, 0);
    wb(1'b0, `SFR_A_VCFG, 0);
    chk("no latch", 32'hdffb, rd);
    cur = '{8'hfb, 8'hdf, 8'h00};
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      spi1(8'h06);
      tx = {wcmd[i], v};
      go(0, 0);
      cur[i] = (v & ~rsv[i]) | (cur[i] & rsv[i]);
      tx = {rcmd[i]};
      go(0, 3);
      for (int k = 0; k < 3; k++) begin
        chk("vol read", {24'h0, cur[i]}, sfr_host_i.rx_q[k]);
      end
    end
    wb(1'b0, `SFR_A_VCFG, 0);
    chk("vol regs", {8'h0, cur[2], cur[1], cur[0]}, rd);
    spi1(8'h06);
    tx = {8'h01, 8'hfc};
    go(3, 0);
    wb(1'b0, `SFR_A_STAT, 0);
    chk("cut write", 32'h8002, rd);
    $display("volatile test done");
    v = 8'($urandom) | 8'h80;
    tx = {8'h01, v};
    go(0, 0);
    tx = {8'h05};
    go(0, 1);
    chk("busy", 32'h03, sfr_host_i.rx_q[0] & 8'h03);
    tx = {8'h70};
    go(0, 1);
    chk("busy flag", 0, sfr_host_i.rx_q[0] & 8'h80);
    waitidle();
    e = v & 8'hfc;
    chk("sr write", {16'h0, 8'h80, e}, rd);
    @(posedge clk_i) wp_n <= 1'b0;
    spi1(8'h06);
    tx = {8'h01, 8'h00};
    go(0, 0);
    waitidle();
    chk("hw protect", {16'h0, 8'h80, e}, rd);
    @(posedge clk_i) wp_n <= 1'b1;
    spi1(8'h06);
    tx = {8'hb1, 8'h00};
    go(0, 0);
    wb(1'b0, `SFR_A_NVCR, 0);
    chk("nv short", 32'hffff, rd);
    nv = 16'($urandom);
    tx = {8'hb1, nv[7:0], nv[15:8]};
    go(0, 0);
    waitidle();
    nv = nv | 16'h0010;
    tx = {8'hb5};
    go(0, 3);
    chk("nv low", {24'h0, nv[7:0]}, sfr_host_i.rx_q[0]);
    chk("nv high", {24'h0, nv[15:8]}, sfr_host_i.rx_q[1]);
    chk("nv tail", 0, sfr_host_i.rx_q[2]);
    $display("self-timed test done");
    foreach (cmds[i]) begin
      for (int p = 0; p < 3; p++) begin
        for (int a = 0; a < 2; a++) begin
          ex = exp_cyc(cmds[i], p, a ? 32 : 24);
          if ((ex < 0 && cmds[i] != 8'he7) || (cmds[i] == 8'h0e && a == 0))
            continue;
          setp(p, 1'(a));
          spi1(cmds[i]);
          wb(1'b0, `SFR_A_INFO, 0);
          if (ex < 0) begin
            chk("word ignored", 32'h1, {31'h0, rd[15]});
          end else begin
            chk("addr cycles", {17'h0, cmds[i] != 8'he7, 6'(ex), cmds[i]},
              rd & 32'hffff);
          end
        end
      end
    end
    wb(1'b1, `SFR_A_CTRL, 32'h08);
    lanes = 1;
    spi1(8'he7);
    wb(1'b0, `SFR_A_INFO, 0);
    ex = exp_cyc(8'he7, 0, 24);
    chk("word dtr", {16'h0, 2'b11, 6'(ex), 8'he7}, rd);
    $display("address phase test done");
    tally_and_finish();
  end
endmodule : sfr_unit_tb
`default_nettype wire
